// [hw/scw_pkg.sv]
// scw_pkg: shared constants for the cyclic command and status word block
// assumes one 200 MHz clock and a host that presents whole words per cycle
package scw_pkg;
    localparam int WORD_W = 16;
    localparam int POS_W = 32;
    localparam int CODE_W = 5;
    localparam int SEL_W = 3;
    // command word fields
    localparam int CMD_POS_OP = 13;
    localparam int CMD_ESTOP = 12;
    localparam int CMD_INDEX_CAP = 11;
    localparam int CMD_INTR_CAP = 10;
    localparam int CMD_INTR_EN = 9;
    localparam int CMD_DEV_CLR = 8;
    localparam int CMD_COAST = 7;
    localparam int CMD_GEN_A = 6;
    localparam int CMD_GEN_B = 5;
    localparam int CMD_SEL_HI = 4;
    localparam int CMD_SEL_LO = 2;
    localparam int CMD_WRITE = 1;
    localparam int CMD_READ = 0;
    // main status word fields
    localparam int ST_READY = 15;
    localparam int ST_INPOS = 14;
    localparam int ST_ALARM = 13;
    localparam int ST_ZERO_DEV = 12;
    localparam int ST_ZERO_SPD = 11;
    localparam int ST_HOME_DONE = 10;
    localparam int ST_TRQ_LIM = 9;
    localparam int ST_DATA_ERR = 8;
    localparam int ST_ESTOP_SEEN = 7;
    localparam int ST_DEV_OVER = 6;
    localparam int ST_CODE_HI = 4;
    // response bit word fields
    localparam int RSP_INDEX_CAP = 6;
    localparam int RSP_INTR_CAP = 5;
    localparam int RSP_SEL_HI = 4;
    localparam int RSP_SEL_LO = 2;
    localparam int RSP_WRITE_DONE = 1;
    localparam int RSP_READ_DONE = 0;
    // reset values and codes
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [POS_W-1:0] POS_RST = 32'h0000_0000;
    localparam logic [CODE_W-1:0] CODE_NONE = 5'h00;
    localparam logic [CODE_W-1:0] CODE_DEV_OVER = 5'h06;
    // parameter access takes this many ns to finish, rounded up to whole cycles in PARAM_CYCLES
    localparam int PARAM_ACCESS_NS = 20;
    localparam int CLK_PERIOD_NS = 5;
    localparam logic [3:0] PARAM_CYCLES =
        4'((PARAM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : scw_pkg

// [hw/scw_capture_if.sv]
// scw_capture_if: capture events and latched position between modules
// assumes both modules run on the same clock
`timescale 1ns/1ps
interface scw_capture_if;
    logic indexHit;
    logic intrHit;
    logic [scw_pkg::POS_W-1:0] capPos;
    modport src (output indexHit, output intrHit, output capPos);
    modport dst (input indexHit, input intrHit, input capPos);
endinterface : scw_capture_if

// [hw/scw_capture.sv]
// scw_capture: arms index and interrupt capture and latches feedback position
// assumes index and interrupt pulses are synchronous single-cycle levels
`timescale 1ns/1ps
module scw_capture (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // arming and events
    input wire logic indexArm,
    input wire logic intrArm,
    input wire logic indexPulse,
    input wire logic intrInput,
    input wire logic [scw_pkg::POS_W-1:0] feedbackPos,
    // results
    scw_capture_if.src cap
);
    typedef struct packed {
        logic indexHit;
        logic intrHit;
        logic [scw_pkg::POS_W-1:0] capPos;
    } scw_cap_state_t;

    scw_cap_state_t state_q, state_d;

    // a disarmed bit drops its flag so the next arm starts clean
    always_comb begin
        state_d = state_q;
        if (!indexArm) begin
            state_d.indexHit = 1'b0;
        end else if (indexPulse && !state_q.indexHit) begin
            state_d.indexHit = 1'b1;
            state_d.capPos = feedbackPos;
        end
        if (!intrArm) begin
            state_d.intrHit = 1'b0;
        end else if (intrInput && !state_q.intrHit) begin
            state_d.intrHit = 1'b1;
            state_d.capPos = feedbackPos;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '{1'b0, 1'b0, scw_pkg::POS_RST};
        end else begin
            state_q <= state_d;
        end
    end

    assign cap.indexHit = state_q.indexHit;
    assign cap.intrHit = state_q.intrHit;
    assign cap.capPos = state_q.capPos;
endmodule : scw_capture

// [hw/scw_words.sv]
// scw_words: cyclic command word decode and status word build
// Operation
// - positioning enabled only while position bit on
// - emergency stop bit holds forced stop
// - index capture sets index-captured flag
// - index capture latches feedback position
// - interrupt capture sets interrupt-captured flag
// - interrupt capture latches feedback position
// - deviation clear on edge or level
// - coast bit removes drive
// - general bits pass to output terminals
// - select bits choose parameter group
// - ready flag when motor can rotate
// - in-position low only while positioning and settled
// - alarm flag set and held
// - zero-deviation flag within range
// - zero-speed flag within width
// - homing-done flag after homing finishes
// - torque-limited flag while at limit
// - data error set, cleared on write removal
// - stop-seen flag while stop input off
// - excess deviation sets flag and alarm
// - alarm code reported, cleared by reset
// - parameter access on read/write rising edge
// - select bits echoed in response
// - write-done and read-done response bits
// assumes the host presents a new command word with busCycle high
// command word layout, bit by bit
// 15:14 unused here, read as don't care
// 13 position operation
// 12 emergency stop
// 11 index capture arm
// 10 interrupt capture arm
// 9 interrupt positioning enable, forwarded only
// 8 deviation clear, edge or level by devClearLevelMode
// 7 coast, drive removed while set
// 6 general command a, or first terminal in pass-through
// 5 general command b, or second terminal in pass-through
// 4:2 data select, echoed back in the response word
// 1 parameter write, acts on its rising edge
// 0 parameter read, acts on its rising edge
// status word layout
// 15 ready
// 14 in-position, low while positioning and settled
// 13 alarm, held until alarmReset
// 12 zero deviation
// 11 zero speed
// 10 homing done, sticky
// 9 torque at limit
// 8 data error, dropped with the write bit
// 7 emergency stop seen, while the stop input is low
// 6 excess deviation, also raises the alarm
// 5 always zero
// 4:0 alarm code, cleared by alarmReset
// response word layout
// 15:7 always zero
// 6 index captured
// 5 interrupt captured
// 4:2 select echo
// 1 write done
// 0 read done
// timing
// a word is taken on the edge that sees busCycle high
// controls and both words change on that same edge
// status inputs are sampled only on that edge, so a short
// pulse between exchanges is not reported unless it latches
// a parameter access runs PARAM_CYCLES edges; edges seen while
// it runs are dropped, so the host must wait for the done bit
// a disarmed capture bit clears its flag on the next edge
// capturedPosition trails the capture flag by one edge
`timescale 1ns/1ps
module scw_words (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // cyclic exchange
    input wire logic busCycle,
    input wire logic [15:0] hostCommandWord,
    output logic [15:0] driveStatusWord,
    output logic [15:0] responseBitWord,
    output logic [31:0] capturedPosition,
    // drive conditions
    input wire logic motorReady,
    input wire logic positionSettled,
    input wire logic alarmDetected,
    input wire logic [4:0] alarmCodeIn,
    input wire logic alarmReset,
    input wire logic deviationInZero,
    input wire logic speedInZero,
    input wire logic homingFinished,
    input wire logic torqueAtLimit,
    input wire logic paramOutOfRange,
    input wire logic emergencyStopInput,
    input wire logic excessDeviation,
    input wire logic indexPulse,
    input wire logic intrInput,
    input wire logic [31:0] feedbackPos,
    input wire logic devClearLevelMode,
    input wire logic generalPassThrough,
    // drive controls
    output logic positionEnable,
    output logic forcedStop,
    output logic driveOff,
    output logic deviationClear,
    output logic intrPositioningEnable,
    output logic generalCommandA,
    output logic generalCommandB,
    output logic outputTerminalFirst,
    output logic outputTerminalSecond,
    output logic [2:0] dataSelect,
    output logic paramRead,
    output logic paramWrite
);
    typedef struct packed {
        logic [15:0] cmd;
        logic [15:0] status;
        logic [15:0] resp;
        logic [31:0] pos;
        logic alarm;
        logic [4:0] code;
        logic dataErr;
        logic homeDone;
        logic [3:0] accCnt;
        logic accWrite;
        logic readDone;
        logic writeDone;
        logic posEn;
        logic stop;
        logic coast;
        logic devClr;
        logic intrEn;
        logic genA;
        logic genB;
        logic outA;
        logic outB;
        logic [2:0] sel;
        logic rdPulse;
        logic wrPulse;
    } scw_state_t;

    scw_state_t state_q, state_d;
    scw_capture_if capBus();

    // pick one command field out of a word
    function automatic logic cmdBit(input logic [15:0] w, input int idx);
        cmdBit = w[idx];
    endfunction : cmdBit

    scw_capture u_capture (
        .clk(clk),
        .reset_n(reset_n),
        .indexArm(cmdBit(state_q.cmd, scw_pkg::CMD_INDEX_CAP)),
        .intrArm(cmdBit(state_q.cmd, scw_pkg::CMD_INTR_CAP)),
        .indexPulse(indexPulse),
        .intrInput(intrInput),
        .feedbackPos(feedbackPos),
        .cap(capBus.src)
    );

    logic [15:0] nextCmd;
    logic rdRise, wrRise, devRise;
    assign nextCmd = busCycle ? hostCommandWord : state_q.cmd;
    // edges are against the previous cycle's word
    assign rdRise = cmdBit(nextCmd, scw_pkg::CMD_READ) &&
        !cmdBit(state_q.cmd, scw_pkg::CMD_READ);
    assign wrRise = cmdBit(nextCmd, scw_pkg::CMD_WRITE) &&
        !cmdBit(state_q.cmd, scw_pkg::CMD_WRITE);
    assign devRise = cmdBit(nextCmd, scw_pkg::CMD_DEV_CLR) &&
        !cmdBit(state_q.cmd, scw_pkg::CMD_DEV_CLR);

    // decode controls, run parameter access, build words
    always_comb begin
        state_d = state_q;
        state_d.cmd = nextCmd;
        state_d.posEn = cmdBit(nextCmd, scw_pkg::CMD_POS_OP);
        state_d.stop = cmdBit(nextCmd, scw_pkg::CMD_ESTOP);
        state_d.coast = cmdBit(nextCmd, scw_pkg::CMD_COAST);
        // host keeps this bit itself; we only forward it
        state_d.intrEn = cmdBit(nextCmd, scw_pkg::CMD_INTR_EN);
        state_d.devClr = devClearLevelMode ?
            cmdBit(nextCmd, scw_pkg::CMD_DEV_CLR) : devRise;
        state_d.genA = generalPassThrough ? 1'b0 :
            cmdBit(nextCmd, scw_pkg::CMD_GEN_A);
        state_d.genB = generalPassThrough ? 1'b0 :
            cmdBit(nextCmd, scw_pkg::CMD_GEN_B);
        state_d.outA = generalPassThrough &&
            cmdBit(nextCmd, scw_pkg::CMD_GEN_A);
        state_d.outB = generalPassThrough &&
            cmdBit(nextCmd, scw_pkg::CMD_GEN_B);
        state_d.sel = nextCmd[scw_pkg::CMD_SEL_HI:scw_pkg::CMD_SEL_LO];
        state_d.rdPulse = 1'b0;
        state_d.wrPulse = 1'b0;
        // done bits drop once the host lifts its command
        if (!cmdBit(nextCmd, scw_pkg::CMD_READ)) begin
            state_d.readDone = 1'b0;
        end
        if (!cmdBit(nextCmd, scw_pkg::CMD_WRITE)) begin
            state_d.writeDone = 1'b0;
            state_d.dataErr = 1'b0;
        end
        // one access at a time; an edge during a busy access is ignored
        if (state_q.accCnt != 4'h0) begin
            state_d.accCnt = state_q.accCnt - 4'h1;
            if (state_q.accCnt == 4'h1) begin
                if (state_q.accWrite) begin
                    state_d.writeDone = 1'b1;
                    if (paramOutOfRange) begin
                        state_d.dataErr = 1'b1;
                    end
                end else begin
                    state_d.readDone = 1'b1;
                end
            end
        end else if (wrRise) begin
            state_d.accCnt = scw_pkg::PARAM_CYCLES;
            state_d.accWrite = 1'b1;
            state_d.wrPulse = 1'b1;
        end else if (rdRise) begin
            state_d.accCnt = scw_pkg::PARAM_CYCLES;
            state_d.accWrite = 1'b0;
            state_d.rdPulse = 1'b1;
        end
        // alarm holds until reset; a new alarm beats a reset
        if (alarmReset) begin
            state_d.alarm = 1'b0;
            state_d.code = scw_pkg::CODE_NONE;
        end
        if (excessDeviation) begin
            state_d.alarm = 1'b1;
            state_d.code = scw_pkg::CODE_DEV_OVER;
        end else if (alarmDetected) begin
            state_d.alarm = 1'b1;
            state_d.code = alarmCodeIn;
        end
        if (cmdBit(nextCmd, scw_pkg::CMD_POS_OP) && !positionSettled) begin
            state_d.homeDone = state_q.homeDone;
        end
        if (homingFinished) begin
            state_d.homeDone = 1'b1;
        end
        if (capBus.indexHit || capBus.intrHit) begin
            state_d.pos = capBus.capPos;
        end
        // status refreshes only on a bus exchange
        if (busCycle) begin
            state_d.status = WORD_BUILD(state_d);
            state_d.resp = '0;
            state_d.resp[scw_pkg::RSP_INDEX_CAP] = capBus.indexHit;
            state_d.resp[scw_pkg::RSP_INTR_CAP] = capBus.intrHit;
            state_d.resp[scw_pkg::RSP_SEL_HI:scw_pkg::RSP_SEL_LO] =
                state_d.sel;
            state_d.resp[scw_pkg::RSP_WRITE_DONE] = state_d.writeDone;
            state_d.resp[scw_pkg::RSP_READ_DONE] = state_d.readDone;
        end
    end

    // assemble the main status word from the next state
    function automatic logic [15:0] WORD_BUILD(input scw_state_t s);
        logic [15:0] w;
        w = scw_pkg::WORD_RST;
        w[scw_pkg::ST_READY] = motorReady;
        w[scw_pkg::ST_INPOS] = !(s.posEn && positionSettled);
        w[scw_pkg::ST_ALARM] = s.alarm;
        w[scw_pkg::ST_ZERO_DEV] = deviationInZero;
        w[scw_pkg::ST_ZERO_SPD] = speedInZero;
        w[scw_pkg::ST_HOME_DONE] = s.homeDone;
        w[scw_pkg::ST_TRQ_LIM] = torqueAtLimit;
        w[scw_pkg::ST_DATA_ERR] = s.dataErr;
        w[scw_pkg::ST_ESTOP_SEEN] = !emergencyStopInput;
        w[scw_pkg::ST_DEV_OVER] = excessDeviation;
        w[scw_pkg::ST_CODE_HI:0] = s.code;
        WORD_BUILD = w;
    endfunction : WORD_BUILD

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // every output comes straight from a state flip-flop
    assign driveStatusWord = state_q.status;
    assign responseBitWord = state_q.resp;
    assign capturedPosition = state_q.pos;
    assign positionEnable = state_q.posEn;
    assign forcedStop = state_q.stop;
    assign driveOff = state_q.coast;
    assign deviationClear = state_q.devClr;
    assign intrPositioningEnable = state_q.intrEn;
    assign generalCommandA = state_q.genA;
    assign generalCommandB = state_q.genB;
    assign outputTerminalFirst = state_q.outA;
    assign outputTerminalSecond = state_q.outB;
    assign dataSelect = state_q.sel;
    assign paramRead = state_q.rdPulse;
    assign paramWrite = state_q.wrPulse;
endmodule : scw_words

// [testbench/scw_words_monitor.sv]
// scw_words_monitor: port-level checker for the cyclic word block
// assumes words are taken on a busCycle edge, outputs follow one edge on
`timescale 1ns/1ps
module scw_chk (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // command side
    input wire logic busCycle,
    input wire logic [15:0] hostCommandWord,
    input wire logic motorReady,
    input wire logic excessDeviation,
    input wire logic generalPassThrough,
    // answer side
    input wire logic [15:0] driveStatusWord,
    input wire logic [15:0] responseBitWord,
    input wire logic positionEnable,
    input wire logic forcedStop,
    input wire logic driveOff,
    input wire logic outputTerminalFirst,
    input wire logic [2:0] dataSelect,
    input wire logic paramWrite
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // a write pulse must come from a taken word that carried the write bit
    sequence s_wrTaken;
        $past(busCycle) && $past(hostCommandWord[1]);
    endsequence
    sequence s_pulseEnd;
        !paramWrite;
    endsequence
    property p_posOp;
        busCycle |=> positionEnable == $past(hostCommandWord[13]);
    endproperty
    property p_stop;
        busCycle |=> forcedStop == $past(hostCommandWord[12]);
    endproperty
    property p_coast;
        busCycle |=> driveOff == $past(hostCommandWord[7]);
    endproperty
    property p_term;
        busCycle && generalPassThrough
            |=> outputTerminalFirst == $past(hostCommandWord[6]);
    endproperty
    property p_sel;
        busCycle |=> dataSelect == $past(hostCommandWord[4:2])
            && responseBitWord[4:2] == dataSelect;
    endproperty
    property p_ready;
        busCycle |=> driveStatusWord[15] == $past(motorReady);
    endproperty
    property p_over;
        busCycle && excessDeviation
            |=> driveStatusWord[6] && driveStatusWord[13];
    endproperty
    property p_wr;
        $rose(paramWrite) |-> s_wrTaken ##1 s_pulseEnd;
    endproperty
    a_posOp: assert property (p_posOp)
        else $error("position enable mismatch");
    a_stop: assert property (p_stop)
        else $error("forced stop mismatch");
    a_coast: assert property (p_coast)
        else $error("drive off mismatch");
    a_term: assert property (p_term)
        else $error("output terminal mismatch");
    a_sel: assert property (p_sel)
        else $error("select or echo mismatch");
    a_ready: assert property (p_ready)
        else $error("ready flag mismatch");
    a_over: assert property (p_over)
        else $error("excess deviation flags missing");
    a_wr: assert property (p_wr)
        else $error("write pulse without write edge");
endmodule : scw_chk

bind scw_words scw_chk u_scw_chk (.clk, .reset_n, .busCycle,
    .hostCommandWord, .motorReady, .excessDeviation, .generalPassThrough,
    .driveStatusWord, .responseBitWord, .positionEnable, .forcedStop,
    .driveOff, .outputTerminalFirst, .dataSelect, .paramWrite);

// [testbench/scw_host_model.sv]
// scw_host: cyclic bus controller model presenting whole command words
// assumes the device takes a word only on the edge that sees busCycle
`timescale 1ns/1ps
module scw_host (
    // clock
    input wire logic clk,
    // cyclic exchange
    output logic busCycle,
    output logic [15:0] hostCommandWord
);
    initial begin
        busCycle = 1'b0;
        hostCommandWord = 16'h0000;
    end
    // one exchange; between cycles the word is scrambled, not held,
    // so a device that samples outside busCycle is caught
    task send(input logic [15:0] w);
        @(posedge clk);
        busCycle <= 1'b1;
        hostCommandWord <= w;
        @(posedge clk);
        busCycle <= 1'b0;
        hostCommandWord <= ~w;
    endtask : send
endmodule : scw_host

// [testbench/tb_scw_words.sv]
// tb_scw_words: self-checking bench for the cyclic command/status words
// assumes the host model is the only source of command words
`timescale 1ns/1ps
module tb_scw_words;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic busCycle, paramRead, paramWrite;
    logic [15:0] hostCommandWord, driveStatusWord, responseBitWord;
    logic [31:0] capturedPosition;
    logic [31:0] feedbackPos = 32'h0000_0000;
    logic [4:0] alarmCodeIn = 5'h00;
    logic motorReady = 1'b0, positionSettled = 1'b0, alarmDetected = 1'b0;
    logic alarmReset = 1'b0, deviationInZero = 1'b0, speedInZero = 1'b0;
    logic homingFinished = 1'b0, torqueAtLimit = 1'b0;
    logic paramOutOfRange = 1'b0, emergencyStopInput = 1'b0;
    logic excessDeviation = 1'b0, indexPulse = 1'b0, intrInput = 1'b0;
    logic devClearLevelMode = 1'b1, generalPassThrough = 1'b1;
    logic positionEnable, forcedStop, driveOff, deviationClear;
    logic intrPositioningEnable, generalCommandA, generalCommandB;
    logic outputTerminalFirst, outputTerminalSecond;
    logic [2:0] dataSelect;
    int fails = 0, checked = 0, wrCount = 0, rdCount = 0;

    scw_host u_scw_host (.clk, .busCycle, .hostCommandWord);
    scw_words u_scw_words (.clk, .reset_n, .busCycle, .hostCommandWord,
        .driveStatusWord, .responseBitWord, .capturedPosition, .motorReady,
        .positionSettled, .alarmDetected, .alarmCodeIn, .alarmReset,
        .deviationInZero, .speedInZero, .homingFinished, .torqueAtLimit,
        .paramOutOfRange, .emergencyStopInput, .excessDeviation,
        .indexPulse, .intrInput, .feedbackPos, .devClearLevelMode,
        .generalPassThrough, .positionEnable, .forcedStop, .driveOff,
        .deviationClear, .intrPositioningEnable, .generalCommandA,
        .generalCommandB, .outputTerminalFirst, .outputTerminalSecond,
        .dataSelect, .paramRead, .paramWrite);

    initial begin
        forever #2.5 clk = ~clk;
    end
    // count access pulses so a doubled or missing pulse shows up
    always @(posedge clk) begin
        if (paramWrite === 1'b1) wrCount++;
        if (paramRead === 1'b1) rdCount++;
    end

    task chk(input string name, input logic [31:0] exp,
             input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // one exchange, then look once the answer edge has landed
    task go(input logic [15:0] w);
        u_scw_host.send(w);
        @(posedge clk);
        #1;
    endtask : go
    task t_commands;
        go(16'h2200);
        chk("positionEnable", 1'b1, positionEnable);
        chk("intrPosEnable", 1'b1, intrPositioningEnable);
        chk("forcedStop", 1'b0, forcedStop);
        go(16'h1180);
        chk("forcedStop", 1'b1, forcedStop);
        chk("driveOff", 1'b1, driveOff);
        chk("positionEnable", 1'b0, positionEnable);
        chk("deviationClear", 1'b1, deviationClear);
        for (int s = 0; s < 8; s++) begin
            go(16'(s << 2));
            chk("dataSelect", 32'(s), dataSelect);
            chk("selectEcho", 32'(s), responseBitWord[4:2]);
        end
    endtask : t_commands
    task t_general;
        go(16'h0040);
        chk("outFirst", 1'b1, outputTerminalFirst);
        chk("outSecond", 1'b0, outputTerminalSecond);
        @(posedge clk) generalPassThrough <= 1'b0;
        go(16'h0020);
        chk("generalB", 1'b1, generalCommandB);
        chk("generalA", 1'b0, generalCommandA);
    endtask : t_general
    task t_status;
        @(posedge clk);
        motorReady <= 1'b1;
        positionSettled <= 1'b1;
        deviationInZero <= 1'b1;
        speedInZero <= 1'b1;
        homingFinished <= 1'b1;
        torqueAtLimit <= 1'b1;
        go(16'h2000);
        chk("statusFlags", 16'h9e00, driveStatusWord & 16'hde00);
        chk("stopSeen", 1'b1, driveStatusWord[7]);
        @(posedge clk);
        positionSettled <= 1'b0;
        emergencyStopInput <= 1'b1;
        go(16'h2000);
        chk("inPosition", 1'b1, driveStatusWord[14]);
        chk("stopSeenOff", 1'b0, driveStatusWord[7]);
    endtask : t_status
    task t_alarm;
        @(posedge clk) excessDeviation <= 1'b1;
        go(16'h0000);
        chk("overFlags", 16'h2040, driveStatusWord & 16'h2040);
        chk("alarmCode", scw_pkg::CODE_DEV_OVER, driveStatusWord[4:0]);
        @(posedge clk) excessDeviation <= 1'b0;
        go(16'h0000);
        chk("alarmHeld", 1'b1, driveStatusWord[13]);
        @(posedge clk) alarmReset <= 1'b1;
        go(16'h0000);
        @(posedge clk) alarmReset <= 1'b0;
        go(16'h0000);
        chk("alarmCleared", 16'h0000, driveStatusWord & 16'h201f);
        // alarm from the generic input carries its own code
        @(posedge clk);
        alarmDetected <= 1'b1;
        alarmCodeIn <= 5'h0b;
        go(16'h0000);
        chk("alarmByInput", 16'h200b, driveStatusWord & 16'h205f);
        @(posedge clk) alarmDetected <= 1'b0;
    endtask : t_alarm
    // edge mode: one pulse on the rising bit, none while it is held
    task t_devEdge;
        @(posedge clk) devClearLevelMode <= 1'b0;
        go(16'h0000);
        u_scw_host.send(16'h0100);
        #1;
        chk("devClearPulse", 1'b1, deviationClear);
        @(posedge clk);
        #1;
        chk("devClearEnd", 1'b0, deviationClear);
        go(16'h0100);
        chk("devClearHeld", 1'b0, deviationClear);
    endtask : t_devEdge
    // word held high across two exchanges must start only one access
    task t_param;
        @(posedge clk) paramOutOfRange <= 1'b1;
        go(16'h0002);
        repeat (6) @(posedge clk);
        go(16'h0002);
        chk("writePulses", 32'd1, 32'(wrCount));
        chk("writeDone", 1'b1, responseBitWord[1]);
        chk("dataError", 1'b1, driveStatusWord[8]);
        go(16'h0000);
        chk("dataErrorOff", 1'b0, driveStatusWord[8]);
        go(16'h0001);
        repeat (6) @(posedge clk);
        go(16'h0001);
        chk("readPulses", 32'd1, 32'(rdCount));
        chk("readDone", 1'b1, responseBitWord[0]);
    endtask : t_param
    task t_capture(input logic [15:0] w, input int b, input logic [31:0] p);
        go(w);
        @(posedge clk);
        feedbackPos <= p;
        indexPulse <= w[11];
        intrInput <= w[10];
        @(posedge clk);
        indexPulse <= 1'b0;
        intrInput <= 1'b0;
        feedbackPos <= ~p;
        go(w);
        chk("captureFlag", 1'b1, responseBitWord[b]);
        chk("capturePos", p, capturedPosition);
    endtask : t_capture
    task results;
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        t_commands();
        t_general();
        t_status();
        t_alarm();
        t_param();
        t_devEdge();
        t_capture(16'h0800, 6, 32'h1234_5678);
        t_capture(16'h0400, 5, 32'h89ab_cdef);
        results();
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        #50000;
        fails++;
        results();
    end
endmodule : tb_scw_words
